// [verilog/htf_core.v]
// Hall/logic_input_a feedback, speed mode, lock, config load, fault and wake logic.
// Assumes 250 MHz mclk, pins synchronised here, Avalon-MM master with waitrequest.
// Behaviour
// - Hall edge blanks further edges for 20us
// - Logic_input_a source: trace, logic input, Hall
// - Hall logic_input_a: XOR of three or Hall U
// - Logic_input_a to speed logic and open-drain pin
// - Power-up config from memory or serial EEPROM
// - Writes anytime; memory programmable only once
// - Serial port usable 10us after reset
// - High-side drive enabled within 1ms of enable
// - Three speed modes: freq, duty, register
// - Frequency mode closes loop on input clock
// - Speed measured from Hall or logic_input_a
// - Programmable pole, zero, integrator gain
// - Duty modes run open loop
// - Start up with three-Hall commutation
// - Locked: lock pin low, single Hall unless basic set
// - Locked plus sine enable: sine drive
// - Commutation shifted by commutation_b register
// - Fault stops drive, fault pin low
// - All logic on one internal clock
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "htf_regs.vh"
module htf_core #(
  parameter WAKE_CYC = `HTF_WAKE_CYC
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [2:0]  hall_in,
  input  wire        trace_cmp_in,
  input  wire        logic_input_a,
  input  wire        speed_clk_in,
  input  wire        enable_in,
  input  wire        fault_in,
  input  wire        config_source_select,
  input  wire        eeprom_valid,
  input  wire [31:0] eeprom_data,
  output reg         eeprom_req,
  output reg  [1:0]  eeprom_addr,
  output wire        logic_input_a_feedback_out,
  output wire        logic_input_a_feedback_oe,
  output reg         logic_input_a_signal,
  output reg         speed_locked_out_n,
  output reg         fault_out_n,
  output reg         hs_drive_en,
  output reg         drive_en,
  output reg         single_hall_mode,
  output reg         sine_mode,
  output reg         closed_loop,
  output reg  [7:0]  commutation_b,
  output reg  [15:0] duty_cmd,
  output reg  [2:0]  hall_clean
);
  localparam ST_LOAD = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN  = 2'h2;

  // Two-flop synchronisers for every pin
  reg [8:0] pin_s1;
  reg [8:0] pin_s2;
  reg [1:0] sync_fill;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1    <= 9'h000;
      pin_s2    <= 9'h000;
      sync_fill <= 2'h0;
    end else begin
      pin_s1    <= {config_source_select, fault_in, enable_in, speed_clk_in, logic_input_a, trace_cmp_in, hall_in};
      pin_s2    <= pin_s1;
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end
  wire [2:0] hall_s   = pin_s2[2:0];
  wire       trace_s  = pin_s2[3];
  wire       logic_input_a_s   = pin_s2[4];
  wire       sclk_s   = pin_s2[5];
  wire       en_s     = pin_s2[6];
  wire       fault_s  = pin_s2[7];
  wire       cfgsel_s = pin_s2[8];

  wire [2:0] hall_d;
  wire [2:0] hall_edge;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_hall
      htf_deglitch #(.CYCLES(`HTF_DEGLITCH_CYC)) u_dg (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .raw        (hall_s[g]),
        .clean      (hall_d[g]),
        .edge_pulse (hall_edge[g])
      );
    end
  endgenerate

  // Control register fields
  reg [31:0] ctrl_reg;
  reg [31:0] speed_reg;
  reg [31:0] loop_reg;
  wire [1:0] logic_input_a_sel   = ctrl_reg[1:0];
  wire       hall_xor   = ctrl_reg[2];
  wire       meas_logic_input_a  = ctrl_reg[3];
  wire       sine_en    = ctrl_reg[4];
  wire       basic      = ctrl_reg[5];
  wire [1:0] speed_mode = ctrl_reg[7:6];

  // Logic_input_a source selection
  reg next_logic_input_a;
  always @* begin
    case (logic_input_a_sel)
      `HTF_TSRC_TRACE: next_logic_input_a = trace_s;
      `HTF_TSRC_LOGIC: next_logic_input_a = logic_input_a_s;
      `HTF_TSRC_HALL:  next_logic_input_a = hall_xor ? ^hall_d : hall_d[0];
      default:         next_logic_input_a = trace_s;
    endcase
  end
  // Open drain: pull low when logic_input_a is low
  assign logic_input_a_feedback_out = 1'b0;
  assign logic_input_a_feedback_oe  = ~logic_input_a_signal;

  // Speed measurement period counter
  reg        logic_input_a_d;
  reg        sclk_d;
  reg [15:0] per_cnt;
  reg [15:0] meas_period;
  reg [15:0] ref_cnt;
  reg [15:0] ref_period;
  reg [15:0] hi_cnt;
  wire meas_edge = meas_logic_input_a ? (logic_input_a_signal & ~logic_input_a_d) : hall_edge[0];
  wire ref_edge  = sclk_s & ~sclk_d;

  // Config load FSM
  reg [1:0]  state;
  reg [1:0]  load_idx;
  reg [15:0] ready_cnt;
  reg        port_ready;
  reg        otp_wr;
  reg [1:0]  otp_addr;
  wire [31:0] otp_rdata;
  wire        otp_burned;

  htf_cfg_mem u_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .addr    (otp_addr),
    .wr      (otp_wr),
    .wdata   (avs_writedata),
    .rdata   (otp_rdata),
    .burned  (otp_burned)
  );

  reg loaded;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_LOAD;
      load_idx    <= 2'h0;
      eeprom_req  <= 1'b0;
      eeprom_addr <= 2'h0;
      loaded      <= 1'b0;
      ready_cnt   <= 16'h0000;
      port_ready  <= 1'b0;
    end else begin
      if (ready_cnt != `HTF_SPI_READY_CYC - 1) begin
        ready_cnt <= ready_cnt + 16'h0001;
      end
      if (ready_cnt == `HTF_SPI_READY_CYC - 1 && loaded) begin
        port_ready <= 1'b1;
      end
      case (state)
        ST_LOAD: begin
          // Wait until the source pin has crossed both flops, else word 0 comes from the wrong source
          if (sync_fill[1]) begin
            eeprom_req  <= cfgsel_s;
            eeprom_addr <= load_idx;
            state       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!cfgsel_s || eeprom_valid) begin
            eeprom_req <= 1'b0;
            if (load_idx == `HTF_CFG_WORDS - 1) begin
              state  <= ST_RUN;
              loaded <= 1'b1;
            end else begin
              load_idx <= load_idx + 2'h1;
              state    <= ST_LOAD;
            end
          end
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_LOAD;
      endcase
    end
  end
  wire [31:0] load_word = cfgsel_s ? eeprom_data : otp_rdata;
  wire        load_take = (state == ST_WAIT) && (!cfgsel_s || eeprom_valid);

  // Bus: waitrequest held until port ready, else one-cycle answer
  reg rd_done;
  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & (~port_ready | (avs_read & ~rd_done));
  wire wr_go = avs_write & port_ready;

  always @* begin
    otp_addr = (state == ST_RUN) ? avs_writedata[31:30] : load_idx;
    otp_wr   = wr_go && avs_address == `HTF_ADDR_OTP && state == ST_RUN;
  end

  reg [7:0] lock_cnt;
  reg       locked;
  reg [15:0] integ;
  reg [15:0] perr;
  wire [15:0] diff = (meas_period > ref_period) ? meas_period - ref_period : ref_period - meas_period;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg      <= `HTF_CTRL_RESET;
      speed_reg     <= 32'h0000_0000;
      loop_reg      <= 32'h0000_0000;
      commutation_b <= 8'h00;
      avs_readdata  <= 32'h0000_0000;
      rd_done       <= 1'b0;
    end else begin
      rd_done <= avs_read & port_ready & ~rd_done;
      if (load_take) begin
        case (load_idx)
          2'h0: ctrl_reg <= load_word;
          2'h1: speed_reg <= load_word;
          2'h2: loop_reg <= load_word;
          default: commutation_b <= load_word[7:0];
        endcase
      end else if (wr_go) begin
        case (avs_address)
          `HTF_ADDR_CTRL:  ctrl_reg <= avs_writedata;
          `HTF_ADDR_SPEED: speed_reg <= avs_writedata;
          `HTF_ADDR_LOOP:  loop_reg <= avs_writedata;
          `HTF_ADDR_ADV:   commutation_b <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_read & port_ready & ~rd_done) begin
        case (avs_address)
          `HTF_ADDR_CTRL:   avs_readdata <= ctrl_reg;
          `HTF_ADDR_SPEED:  avs_readdata <= speed_reg;
          `HTF_ADDR_LOOP:   avs_readdata <= loop_reg;
          `HTF_ADDR_ADV:    avs_readdata <= {24'h000000, commutation_b};
          `HTF_ADDR_STATUS: avs_readdata <= {24'h000000, otp_burned, sine_mode, single_hall_mode, hs_drive_en,
                                             fault_out_n, speed_locked_out_n, logic_input_a_signal, loaded};
          `HTF_ADDR_PERIOD: avs_readdata <= {ref_period, meas_period};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Speed, loop, lock, drive
  reg [31:0] wake_cnt;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      logic_input_a_signal        <= 1'b0;
      logic_input_a_d             <= 1'b0;
      sclk_d             <= 1'b0;
      per_cnt            <= 16'h0000;
      meas_period        <= 16'h0000;
      ref_cnt            <= 16'h0000;
      ref_period         <= 16'h0000;
      hi_cnt             <= 16'h0000;
      duty_cmd           <= 16'h0000;
      closed_loop        <= 1'b0;
      integ              <= 16'h0000;
      perr               <= 16'h0000;
      lock_cnt           <= 8'h00;
      locked             <= 1'b0;
      speed_locked_out_n <= 1'b1;
      single_hall_mode   <= 1'b0;
      sine_mode          <= 1'b0;
      fault_out_n        <= 1'b1;
      drive_en           <= 1'b0;
      hs_drive_en        <= 1'b0;
      wake_cnt           <= 32'h0000_0000;
      hall_clean         <= 3'h0;
    end else begin
      logic_input_a_signal <= next_logic_input_a;
      logic_input_a_d      <= logic_input_a_signal;
      sclk_d      <= sclk_s;
      hall_clean  <= hall_d;
      per_cnt <= meas_edge ? 16'h0000 : per_cnt + 16'h0001;
      if (meas_edge) meas_period <= per_cnt;
      ref_cnt <= ref_edge ? 16'h0000 : ref_cnt + 16'h0001;
      if (ref_edge) ref_period <= ref_cnt;
      hi_cnt <= ref_edge ? 16'h0000 : (sclk_s ? hi_cnt + 16'h0001 : hi_cnt);
      closed_loop <= (speed_mode == `HTF_MODE_FREQ);
      case (speed_mode)
        `HTF_MODE_FREQ: begin
          // PI style trim: error scaled by pole/zero shift and gain
          if (meas_edge) begin
            perr  <= (meas_period - ref_period) >> loop_reg[3:0];
            integ <= integ + ((meas_period - ref_period) >> loop_reg[11:8]);
          end
          duty_cmd <= integ + (perr >> loop_reg[7:4]);
        end
        `HTF_MODE_PWM: begin
          if (ref_edge) duty_cmd <= hi_cnt;
          integ <= 16'h0000;
        end
        `HTF_MODE_REG: begin
          duty_cmd <= speed_reg[15:0];
          integ    <= 16'h0000;
        end
        default: duty_cmd <= 16'h0000;
      endcase
      // Lock: consecutive periods within tolerance
      if (!drive_en) begin
        lock_cnt <= 8'h00;
        locked   <= 1'b0;
      end else if (meas_edge) begin
        if (diff <= `HTF_LOCK_TOL && meas_period != 16'h0000) begin
          if (lock_cnt != `HTF_LOCK_CNT) lock_cnt <= lock_cnt + 8'h01;
          else locked <= 1'b1;
        end else begin
          lock_cnt <= 8'h00;
          locked   <= 1'b0;
        end
      end
      speed_locked_out_n <= ~locked;
      single_hall_mode   <= locked & ~basic;
      sine_mode          <= locked & sine_en;
      fault_out_n        <= ~fault_s;
      // Wake timer: high-side drive enabled once enable has been held for WAKE_CYC cycles
      if (!en_s || fault_s) begin
        wake_cnt    <= 32'h0000_0000;
        hs_drive_en <= 1'b0;
        drive_en    <= 1'b0;
      end else begin
        drive_en <= 1'b1;
        if (wake_cnt != WAKE_CYC - 1) wake_cnt <= wake_cnt + 32'h0000_0001;
        else hs_drive_en <= 1'b1;
      end
    end
  end
  // commutation_b carries the commutation_b shift to the commutator mclk is the one clock
endmodule
`default_nettype wire

// [verilog/htf_regs.vh]
// Constants for the Hall/logic_input_a feedback and supervision logic.
// Assumes a 250 MHz mclk and a 32-bit Avalon-MM register port.
`ifndef HTF_REGS_VH
`define HTF_REGS_VH

`define HTF_CLK_MHZ        250
`define HTF_DEGLITCH_US    20
`define HTF_DEGLITCH_CYC   (`HTF_DEGLITCH_US * `HTF_CLK_MHZ)
`define HTF_SPI_READY_US   10
`define HTF_SPI_READY_CYC  (`HTF_SPI_READY_US * `HTF_CLK_MHZ)
`define HTF_WAKE_MS        1
`define HTF_WAKE_CYC       (`HTF_WAKE_MS * 1000 * `HTF_CLK_MHZ)
`define HTF_LOCK_TOL       16'h0008
`define HTF_LOCK_CNT       8'h10

`define HTF_ADDR_CTRL      4'h0
`define HTF_ADDR_SPEED     4'h1
`define HTF_ADDR_LOOP      4'h2
`define HTF_ADDR_ADV       4'h3
`define HTF_ADDR_STATUS    4'h4
`define HTF_ADDR_PERIOD    4'h5
`define HTF_ADDR_OTP       4'h6
`define HTF_ADDR_SRC_W     4

`define HTF_CTRL_RESET     32'h0000_0000
`define HTF_TSRC_TRACE     2'h0
`define HTF_TSRC_LOGIC     2'h1
`define HTF_TSRC_HALL      2'h2
`define HTF_MODE_FREQ      2'h0
`define HTF_MODE_PWM       2'h1
`define HTF_MODE_REG       2'h2

`define HTF_CFG_WORDS      4
`define HTF_CFG_AW         2

`endif

// [verilog/htf_deglitch.v]
// One Hall input deglitcher: first edge accepted, then a blanking window.
// Assumes the input is already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module htf_deglitch #(
  parameter CYCLES = 5000
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        raw,
  output reg         clean,
  output reg         edge_pulse
);
  reg [15:0] hold_cnt;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clean      <= 1'b0;
      edge_pulse <= 1'b0;
      hold_cnt   <= 16'h0000;
    end else begin
      edge_pulse <= 1'b0;
      if (hold_cnt != 16'h0000) begin
        // Edges inside the window are dropped and do not restart it
        hold_cnt <= hold_cnt - 16'h0001;
      end else if (raw != clean) begin
        clean      <= raw;
        edge_pulse <= 1'b1;
        hold_cnt   <= CYCLES[15:0] - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/htf_cfg_mem.v]
// Small configuration store standing in for the one-time-programmable array.
// Read data come out of a register; a write-once lock sits per word.
`timescale 1ns/1ps
`default_nettype none
`include "htf_regs.vh"
module htf_cfg_mem (
  input  wire                    mclk,
  input  wire                    reset_n,
  input  wire [`HTF_CFG_AW-1:0]  addr,
  input  wire                    wr,
  input  wire [31:0]             wdata,
  output reg  [31:0]             rdata,
  output wire                    burned
);
  reg [31:0]               mem [0:`HTF_CFG_WORDS-1];
  reg [`HTF_CFG_WORDS-1:0] used = {`HTF_CFG_WORDS{1'b0}};

  assign burned = used[addr];

  // Cells and burn marks survive reset: they stand for non-volatile storage
  always @(posedge mclk) begin
    // Second program of a word is ignored
    if (wr && !used[addr]) begin
      mem[addr]  <= wdata;
      used[addr] <= 1'b1;
    end
  end

  // Unprogrammed words read as zero
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= used[addr] ? mem[addr] : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// [verif/htf_props.sv]
// Checker for the Hall/logic_input_a core: bus stall, logic_input_a pin, Hall window, wake, fault.
// Assumes only the core's ports; bound to htf_core at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "htf_regs.vh"
module htf_chk #(
  parameter int WAKE_CYC = 50
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        enable_in,
  input wire logic        fault_in,
  input wire logic        logic_input_a_feedback_out,
  input wire logic        logic_input_a_feedback_oe,
  input wire logic        logic_input_a_signal,
  input wire logic        speed_locked_out_n,
  input wire logic        fault_out_n,
  input wire logic        hs_drive_en,
  input wire logic        drive_en,
  input wire logic        single_hall_mode,
  input wire logic        sine_mode,
  input wire logic [2:0]  hall_clean
);
  localparam int RDY  = `HTF_SPI_READY_CYC;
  localparam int DG   = `HTF_DEGLITCH_CYC;
  localparam int WMAX = WAKE_CYC + 8;
  int   rc;
  int   hc;
  int   wc;
  logic hq;
  logic seen;
  // Slack of a few cycles covers synchroniser latency
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rc <= 0;
      hc <= 0;
      wc <= 0;
      hq <= 1'b0;
      seen <= 1'b0;
    end else begin
      rc <= (rc < RDY) ? rc + 1 : rc;
      hq <= hall_clean[0];
      seen <= seen | (hq != hall_clean[0]);
      hc <= (hq != hall_clean[0]) ? 0 : ((hc < DG) ? hc + 1 : hc);
      wc <= (!enable_in || hs_drive_en || fault_in || !fault_out_n) ? 0 : wc + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_port_stall: assert property ((avs_read || avs_write) && rc < RDY - 2 |-> avs_waitrequest)
    else $error("bus served before port ready");
  chk_fault_stop: assert property (fault_in [*5] |-> !fault_out_n && !drive_en && !hs_drive_en)
    else $error("fault did not stop drive");
  chk_fault_nodrive: assert property (!fault_out_n |-> !drive_en && !hs_drive_en)
    else $error("drive active while fault shown");
  chk_logic_input_a_pin: assert property (logic_input_a_feedback_oe == !logic_input_a_signal && !logic_input_a_feedback_out)
    else $error("logic_input_a pin does not follow logic_input_a signal");
  chk_hall_window: assert property (seen && hq != hall_clean[0] |-> hc >= DG - 3)
    else $error("hall edge accepted inside window");
  chk_wake_bound: assert property (wc <= WMAX)
    else $error("high side drive late after enable");
  chk_single_lock: assert property (single_hall_mode |-> !speed_locked_out_n)
    else $error("single hall without lock");
  chk_sine_lock: assert property (sine_mode |-> !speed_locked_out_n)
    else $error("sine drive without lock");
  cov_wake: cover property ($rose(hs_drive_en));
  cov_fault: cover property ($fell(fault_out_n));
  cov_hall: cover property (seen && hq != hall_clean[0]);
  cov_lock: cover property ($fell(speed_locked_out_n));
endmodule
bind htf_core htf_chk #(.WAKE_CYC(WAKE_CYC)) u_chk (.mclk(mclk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .enable_in(enable_in), .fault_in(fault_in),
  .logic_input_a_feedback_out(logic_input_a_feedback_out), .logic_input_a_feedback_oe(logic_input_a_feedback_oe), .logic_input_a_signal(logic_input_a_signal),
  .speed_locked_out_n(speed_locked_out_n), .fault_out_n(fault_out_n), .hs_drive_en(hs_drive_en),
  .drive_en(drive_en), .single_hall_mode(single_hall_mode), .sine_mode(sine_mode), .hall_clean(hall_clean));
`default_nettype wire

// [verif/htf_far.sv]
// Far side: Hall sensors and a serial configuration memory.
// Assumes the core holds request and address until it has taken a word.
`timescale 1ns/1ps
`default_nettype none
module htf_far #(
  parameter int LAT = 3
) (
  input  wire logic        mclk,
  input  wire logic [2:0]  hall_set,
  output logic      [2:0]  hall_in,
  input  wire logic        eeprom_req,
  input  wire logic [1:0]  eeprom_addr,
  output logic             eeprom_valid,
  output logic      [31:0] eeprom_data
);
  logic [31:0] rom [4] = '{32'h6, 32'h1234, 32'h321, 32'h55};
  logic [1:0]  la = 2'h0;
  int          n = 0;
  initial begin
    hall_in = 3'h0;
    eeprom_valid = 1'b0;
    eeprom_data = 32'h0;
  end
  // Answer only once the address has stood LAT cycles; idle data toggles
  always @(posedge mclk) begin
    hall_in <= hall_set;
    la <= eeprom_addr;
    n <= (eeprom_req && eeprom_addr == la) ? n + 1 : 0;
    eeprom_valid <= eeprom_req && n >= LAT;
    eeprom_data <= (eeprom_req && n >= LAT) ? rom[eeprom_addr] : ~eeprom_data;
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Testbench: Avalon register tasks, logic_input_a source, Hall window, modes, fault, config load.
// Assumes htf_core with a short wake count and the far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "htf_regs.vh"
module tb;
  localparam int WAKE = 50;
  localparam int DG   = `HTF_DEGLITCH_CYC;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [2:0]  hall_set = 3'h0;
  logic        trace_cmp_in = 1'b0;
  logic        logic_input_a = 1'b0;
  logic        enable_in = 1'b0;
  logic        fault_in = 1'b0;
  logic        config_source_select = 1'b0;
  logic        speed_clk = 1'b0;
  logic [31:0] src [4] = '{32'h0, 32'h1, 32'h6, 32'h2};
  logic [7:0]  exp_logic_input_a = 8'h69;
  logic [31:0] rd;
  wire  [31:0] avs_readdata, eeprom_data;
  wire  [2:0]  hall_in, hall_clean;
  wire  [1:0]  eeprom_addr;
  wire  [7:0]  commutation_b;
  wire  [15:0] duty_cmd;
  wire         avs_waitrequest, eeprom_req, eeprom_valid, logic_input_a_feedback_out, logic_input_a_feedback_oe, logic_input_a_signal;
  wire         speed_locked_out_n, fault_out_n, hs_drive_en, drive_en, single_hall_mode, sine_mode, closed_loop;
  wire         logic_input_a_pin = logic_input_a_feedback_oe ? logic_input_a_feedback_out : 1'b1;
  int          checked = 0;
  int          bad_count = 0;
  int          cyc = 0;
  int          t0 = 0;
  int          i;
  int          n;
  always #2 mclk = ~mclk;
  htf_far u_far (.mclk(mclk), .hall_set(hall_set), .hall_in(hall_in), .eeprom_req(eeprom_req),
    .eeprom_addr(eeprom_addr), .eeprom_valid(eeprom_valid), .eeprom_data(eeprom_data));
  htf_core #(.WAKE_CYC(WAKE)) uut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hall_in(hall_in), .trace_cmp_in(trace_cmp_in),
    .logic_input_a(logic_input_a), .speed_clk_in(speed_clk), .enable_in(enable_in), .fault_in(fault_in),
    .config_source_select(config_source_select), .eeprom_valid(eeprom_valid), .eeprom_data(eeprom_data),
    .eeprom_req(eeprom_req), .eeprom_addr(eeprom_addr), .logic_input_a_feedback_out(logic_input_a_feedback_out),
    .logic_input_a_feedback_oe(logic_input_a_feedback_oe), .logic_input_a_signal(logic_input_a_signal), .speed_locked_out_n(speed_locked_out_n),
    .fault_out_n(fault_out_n), .hs_drive_en(hs_drive_en), .drive_en(drive_en),
    .single_hall_mode(single_hall_mode), .sine_mode(sine_mode), .closed_loop(closed_loop),
    .commutation_b(commutation_b), .duty_cmd(duty_cmd), .hall_clean(hall_clean));
  task automatic complete_run;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Ceiling well above the roughly 26k cycles the sequence needs
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle edge first, so a strobe is never assigned twice in one time step
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic do_reset(input logic sel);
    reset_n <= 1'b0;
    config_source_select <= sel;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t0 = cyc;
  endtask
  initial begin
    do_reset(1'b0);
    bus(`HTF_ADDR_CTRL, 1'b0, 32'h0, rd);
    cmp(cyc - t0 >= `HTF_SPI_READY_CYC - 4, 1);
    cmp(cyc - t0 <= `HTF_SPI_READY_CYC + 8, 1);
    cmp(rd, 32'h0);
    cmp({speed_locked_out_n, single_hall_mode}, 2'b10);
    for (i = 0; i < 8; i = i + 1) begin
      if (i % 4 == 0) begin
        trace_cmp_in <= (i == 0);
        logic_input_a <= (i == 4);
        hall_set <= (i == 0) ? 3'h3 : 3'h4;
        repeat (DG + 100) @(posedge mclk);
      end
      bus(`HTF_ADDR_CTRL, 1'b1, src[i % 4], rd);
      repeat (8) @(posedge mclk);
      cmp(logic_input_a_pin, exp_logic_input_a[i]);
    end
    hall_set <= 3'h5;
    repeat (20) @(posedge mclk);
    cmp(hall_clean, 3'h5);
    hall_set <= 3'h4;
    repeat (2000) @(posedge mclk);
    cmp(hall_clean, 3'h5);
    repeat (DG) @(posedge mclk);
    enable_in <= 1'b1;
    n = 0;
    while (hs_drive_en !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n = n + 1;
    end
    cmp(n <= WAKE + 8, 1);
    bus(`HTF_ADDR_SPEED, 1'b1, 32'h4321, rd);
    for (i = 0; i < 3; i = i + 1) begin
      bus(`HTF_ADDR_CTRL, 1'b1, i << 6, rd);
      repeat (4) @(posedge mclk);
      cmp(closed_loop, i == 0);
    end
    cmp(duty_cmd, 32'h4321);
    // Logic_input_a from logic input, measured from logic_input_a, sine enabled; reference matches logic_input_a period
    bus(`HTF_ADDR_CTRL, 1'b1, 32'h19, rd);
    for (i = 0; i < 60; i = i + 1) begin
      logic_input_a <= ~logic_input_a;
      speed_clk <= ~speed_clk;
      repeat (20) @(posedge mclk);
    end
    cmp({speed_locked_out_n, single_hall_mode, sine_mode}, 3'b011);
    bus(`HTF_ADDR_ADV, 1'b1, 32'h5a, rd);
    bus(`HTF_ADDR_ADV, 1'b0, 32'h0, rd);
    cmp(rd, 32'h5a);
    cmp(commutation_b, 8'h5a);
    bus(4'hf, 1'b0, 32'h0, rd);
    cmp(rd, 32'h0);
    fault_in <= 1'b1;
    repeat (8) @(posedge mclk);
    cmp({fault_out_n, drive_en, hs_drive_en}, 3'b000);
    fault_in <= 1'b0;
    enable_in <= 1'b0;
    bus(`HTF_ADDR_OTP, 1'b1, 32'h1, rd);
    bus(`HTF_ADDR_OTP, 1'b1, 32'h2, rd);
    bus(`HTF_ADDR_STATUS, 1'b0, 32'h0, rd);
    cmp(rd[7], 1);
    do_reset(1'b0);
    bus(`HTF_ADDR_CTRL, 1'b0, 32'h0, rd);
    cmp(rd, 32'h1);
    do_reset(1'b1);
    bus(`HTF_ADDR_CTRL, 1'b0, 32'h0, rd);
    cmp(rd, 32'h6);
    cmp(commutation_b, 8'h55);
    complete_run;
  end
endmodule
`default_nettype wire
